/* rtl/charge_led_cfg.svh */
// Register offsets, reset values and timing figures of the charge level LED display.
`ifndef CHARGE_LED_CFG_SVH
`define CHARGE_LED_CFG_SVH

`define CLK_PERIOD_NS 10
`define PCT_STEP_NS 7812500
`define SHIFT_HALF_NS 250
`define SHIFT_HALF_CYCLES (`SHIFT_HALF_NS / `CLK_PERIOD_NS)

`define OFF_DISPLAY_CONFIG 8'h00
`define OFF_CONTROL 8'h04
`define OFF_CHARGE 8'h08
`define OFF_HEALTH 8'h0C
`define OFF_HOLD 8'h10
`define OFF_STATUS 8'h14

`define RST_DISPLAY_CONFIG 8'h00
`define RST_CONTROL 3'h0
`define RST_HOLD 8'h04

`define CFG_MODE_LSB 0
`define CFG_AON_BIT 3
`define CFG_COUNT_LSB 4
`define CTL_HEALTH_BIT 0
`define CTL_FORCE_ON_BIT 1
`define CTL_FORCE_OFF_BIT 2

`define MODE_NONE 3'h0
`define MODE_SINGLE 3'h1
`define MODE_FOUR 3'h2
`define MODE_EXT_TWO_WIRE 3'h3
`define MODE_EXT_ONE_WIRE 3'h4

`define SINGLE_CLAMP_PCT 7'h5A
`define FULL_PCT 7'h64
`define QUARTER_PCT 7'h19
`define ARM_SECONDS 8'h01

`endif

/* rtl/charge_led_pkg.sv */
// Types shared by the charge level LED display and its serial shifter.
package charge_led_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM = 4'b0010,
        ST_SHOW = 4'b0100,
        ST_RELEASE = 4'b1000
    } disp_state_t;

    typedef enum logic [2:0] {
        SH_IDLE = 3'b001,
        SH_SETUP = 3'b010,
        SH_HIGH = 3'b100
    } shift_state_t;

    typedef struct packed {
        shift_state_t st;
        logic [7:0] div;
        logic [4:0] idx;
        logic [15:0] pat;
        logic sclk;
        logic sdata;
    } shift_regs_t;

    typedef struct packed {
        logic sense_meta;
        logic sense_sync;
        logic [7:0] cfg;
        logic [2:0] ctrl;
        logic [6:0] charge;
        logic [6:0] health;
        logic [7:0] hold;
        disp_state_t st;
        logic [31:0] sub;
        logic [6:0] slot;
        logic [7:0] secs;
        logic [15:0] sent;
        logic refresh;
        logic pin_clk;
        logic pin_dat;
        logic lamp3;
        logic lamp4;
    } disp_regs_t;

endpackage

/* rtl/shift_if.sv */
// Request and pin signals between the display controller and its serial shifter.
`timescale 1ns/100ps
interface shift_if;
    logic start;
    logic [15:0] pattern;
    logic [4:0] count;
    logic busy;
    logic sclk;
    logic sdata;
    modport ctl (output start, output pattern, output count, input busy, input sclk, input sdata);
    modport sh (input start, input pattern, input count, output busy, output sclk, output sdata);
endinterface

/* rtl/led_shifter.sv */
// Bit-banged clock and data serializer feeding chained 8-bit serial shift registers.
`timescale 1ns/100ps
`include "charge_led_cfg.svh"
module led_shifter
    import charge_led_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    shift_if.sh port
);

    shift_regs_t r_q;
    shift_regs_t r_d;
    localparam logic [7:0] HALF = 8'(`SHIFT_HALF_CYCLES - 1);

    // Data changes only while the clock is low, so it is stable around each rising edge.
    always_comb begin
        r_d = r_q;
        case (r_q.st)
            SH_IDLE: begin
                if (port.start && port.count != 5'h00) begin
                    r_d.pat = port.pattern;
                    r_d.idx = port.count;
                    r_d.div = 8'h00;
                    r_d.sdata = port.pattern[4'(port.count - 5'h01)];
                    r_d.st = SH_SETUP;
                end
            end
            SH_SETUP: begin
                r_d.div = r_q.div + 8'h01;
                // The next bit is loaded one cycle after the clock fell, so it never moves on a clock edge.
                if (r_q.div == 8'h00) begin
                    r_d.sdata = r_q.pat[4'(r_q.idx - 5'h01)];
                end
                if (r_q.div == HALF) begin
                    r_d.div = 8'h00;
                    r_d.sclk = 1'b1;
                    r_d.st = SH_HIGH;
                end
            end
            SH_HIGH: begin
                r_d.div = r_q.div + 8'h01;
                if (r_q.div == HALF) begin
                    r_d.div = 8'h00;
                    r_d.sclk = 1'b0;
                    r_d.idx = r_q.idx - 5'h01;
                    if (r_q.idx == 5'h01) begin
                        r_d.st = SH_IDLE;
                    end else begin
                        r_d.st = SH_SETUP;
                    end
                end
            end
            default: r_d.st = SH_IDLE;
        endcase
    end

    // All shifter state is registered here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{st: SH_IDLE, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign port.busy = (r_q.st != SH_IDLE);
    assign port.sclk = r_q.sclk;
    assign port.sdata = r_q.sdata;

    property p_data_stable_on_clock;
        @(posedge pclk) disable iff (!presetn)
        $changed(r_q.sdata) |-> (!r_q.sclk && !$past(r_q.sclk));
    endproperty
    a_data_stable_on_clock: assert property (p_data_stable_on_clock)
        else $error("Shift data changed next to a clock high phase.");

    property p_one_bit_per_clock;
        @(posedge pclk) disable iff (!presetn)
        (r_q.st == SH_HIGH && r_q.div == HALF) |=> (r_q.idx == $past(r_q.idx) - 5'h01) && !r_q.sclk;
    endproperty
    a_one_bit_per_clock: assert property (p_one_bit_per_clock)
        else $error("Shift clock pulse did not consume exactly one bit.");

endmodule // led_shifter

/* rtl/charge_level_led_display.sv */
// Charge or health LED display controller with an APB register port.
`timescale 1ns/100ps
`include "charge_led_cfg.svh"
module charge_level_led_display
    import charge_led_pkg::*;
#(
    parameter int unsigned PCT_CYCLES = `PCT_STEP_NS / `CLK_PERIOD_NS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic display_enable_sense,
    output logic shift_clock_out,
    output logic shift_data_out,
    output logic lamp3_out,
    output logic lamp4_out
);

    disp_regs_t r_q;
    disp_regs_t r_d;
    shift_if sh_bus ();

    logic wr_en;
    logic mapped;
    logic [2:0] mode;
    logic aon_eff;
    logic force_on;
    logic force_off;
    logic active;
    logic ext_mode;
    logic [4:0] led_count;
    logic [6:0] value;
    logic [6:0] single_pct;
    logic [2:0] four_lit;
    logic [4:0] ext_lit;
    logic [15:0] want;
    logic slot_tick;
    logic sec_tick;
    logic [7:0] hold_eff;
    logic single_on;

    // Thermometer code: the lowest n bits set.
    function automatic logic [15:0] therm(input logic [4:0] n);
        logic [16:0] t;
        t = (17'h00001 << n) - 17'h00001;
        return t[15:0];
    endfunction

    // Number of lit steps, rounding any started step up.
    function automatic logic [4:0] steps_lit(input logic [6:0] pct, input logic [4:0] leds);
        logic [10:0] prod;
        prod = 11'(pct) * 11'(leds) + 11'(`FULL_PCT) - 11'h001;
        return 5'(prod / 11'(`FULL_PCT));
    endfunction

    // Configuration decode and the shown quantity.
    assign mode = r_q.cfg[`CFG_MODE_LSB +: 3];
    assign ext_mode = (mode == `MODE_EXT_TWO_WIRE) || (mode == `MODE_EXT_ONE_WIRE);
    assign aon_eff = r_q.cfg[`CFG_AON_BIT] && (mode == `MODE_FOUR || ext_mode);
    assign led_count = (r_q.cfg[`CFG_COUNT_LSB +: 4] == 4'h0) ? 5'h00 :
                       5'(r_q.cfg[`CFG_COUNT_LSB +: 4]) + 5'h01;
    assign value = r_q.ctrl[`CTL_HEALTH_BIT] ? r_q.health : r_q.charge;
    assign force_off = r_q.ctrl[`CTL_FORCE_OFF_BIT];
    assign force_on = r_q.ctrl[`CTL_FORCE_ON_BIT] && !force_off;
    assign active = (r_q.st == ST_SHOW);
    assign hold_eff = (r_q.hold == 8'h00) ? 8'h01 : r_q.hold;

    // A second is exactly 128 percent slots of 7.8125 ms, so one counter serves both rates.
    assign slot_tick = (r_q.sub == PCT_CYCLES - 1);
    assign sec_tick = slot_tick && (r_q.slot == 7'h7F);

    // Shown quantities for each mode, with the test controls taking priority.
    assign single_pct = (value > `SINGLE_CLAMP_PCT) ? `SINGLE_CLAMP_PCT : value;
    assign single_on = force_on || (!force_off && active && (r_q.slot < single_pct));
    assign four_lit = force_off ? 3'h0 : force_on ? 3'h4 :
                      active ? 3'(steps_lit(value, 5'h04)) : 3'h0;
    assign ext_lit = force_off ? 5'h00 : force_on ? led_count :
                     active ? steps_lit(value, led_count) : 5'h00;
    assign want = therm(ext_lit);

    // In an external mode the idle shifter is restarted whenever the wanted pattern differs from the one last sent, or on a refresh.
    assign sh_bus.start = ext_mode && !sh_bus.busy && ((want != r_q.sent) || r_q.refresh);
    assign sh_bus.pattern = want;
    assign sh_bus.count = led_count;

    led_shifter u_shifter (
        .pclk(pclk),
        .presetn(presetn),
        .port(sh_bus.sh)
    );

    // APB decode: zero wait states, error on an unmapped address.
    assign wr_en = psel && penable && pwrite;
    assign pready = 1'b1;
    assign mapped = (paddr == `OFF_DISPLAY_CONFIG) || (paddr == `OFF_CONTROL) || (paddr == `OFF_CHARGE) ||
                    (paddr == `OFF_HEALTH) || (paddr == `OFF_HOLD) || (paddr == `OFF_STATUS);
    assign pslverr = psel && penable && !mapped;

    // Read data mux; the status word shows the sequencer state, shifter activity and lit count.
    always_comb begin
        prdata = 32'h00000000;
        if (paddr == `OFF_DISPLAY_CONFIG) begin
            prdata = {24'h000000, r_q.cfg};
        end else if (paddr == `OFF_CONTROL) begin
            prdata = {29'h00000000, r_q.ctrl};
        end else if (paddr == `OFF_CHARGE) begin
            prdata = {25'h0000000, r_q.charge};
        end else if (paddr == `OFF_HEALTH) begin
            prdata = {25'h0000000, r_q.health};
        end else if (paddr == `OFF_HOLD) begin
            prdata = {24'h000000, r_q.hold};
        end else if (paddr == `OFF_STATUS) begin
            prdata = {19'h00000, ext_lit, 3'h0, sh_bus.busy, r_q.st};
        end
    end

    // Next-state logic for the registers, the timebase, the sequencer and the pins.
    always_comb begin
        r_d = r_q;
        r_d.sense_meta = display_enable_sense;
        r_d.sense_sync = r_q.sense_meta;
        if (wr_en) begin
            if (paddr == `OFF_DISPLAY_CONFIG) begin
                r_d.cfg = pwdata[7:0];
            end else if (paddr == `OFF_CONTROL) begin
                r_d.ctrl = pwdata[2:0];
            end else if (paddr == `OFF_CHARGE) begin
                r_d.charge = (pwdata[6:0] > `FULL_PCT) ? `FULL_PCT : pwdata[6:0];
            end else if (paddr == `OFF_HEALTH) begin
                r_d.health = (pwdata[6:0] > `FULL_PCT) ? `FULL_PCT : pwdata[6:0];
            end else if (paddr == `OFF_HOLD) begin
                r_d.hold = pwdata[7:0];
            end
        end
        r_d.sub = slot_tick ? 32'h00000000 : r_q.sub + 32'h00000001;
        if (slot_tick) begin
            r_d.slot = r_q.slot + 7'h01;
        end
        case (r_q.st)
            ST_IDLE: begin
                r_d.secs = 8'h00;
                if (aon_eff) begin
                    r_d.st = ST_SHOW;
                end else if (r_q.sense_sync) begin
                    r_d.st = ST_ARM;
                end
            end
            ST_ARM: begin
                // The first second tick lands anywhere in the first second, the second one ends the hold.
                // Always-on set while the button is held takes over at once.
                if (aon_eff) begin
                    r_d.st = ST_SHOW;
                end else if (!r_q.sense_sync) begin
                    r_d.st = ST_IDLE;
                end else if (sec_tick) begin
                    r_d.secs = r_q.secs + 8'h01;
                    if (r_q.secs == `ARM_SECONDS) begin
                        r_d.secs = 8'h00;
                        r_d.st = ST_SHOW;
                    end
                end
            end
            ST_SHOW: begin
                if (sec_tick) begin
                    r_d.secs = r_q.secs + 8'h01;
                    if (r_q.secs + 8'h01 >= hold_eff) begin
                        r_d.secs = 8'h00;
                        if (aon_eff) begin
                            r_d.refresh = 1'b1;
                        end else begin
                            r_d.st = ST_RELEASE;
                        end
                    end
                end
            end
            ST_RELEASE: begin
                // A button still held after time-out must not relight the display at once.
                r_d.secs = 8'h00;
                if (aon_eff) begin
                    r_d.st = ST_SHOW;
                end else if (!r_q.sense_sync) begin
                    r_d.st = ST_IDLE;
                end
            end
            default: r_d.st = ST_IDLE;
        endcase
        if (sh_bus.start) begin
            r_d.sent = want;
            r_d.refresh = r_d.st == ST_SHOW && r_q.st == ST_SHOW && r_d.secs == 8'h00 && sec_tick && aon_eff;
        end
        r_d.pin_clk = 1'b0;
        r_d.pin_dat = 1'b0;
        r_d.lamp3 = 1'b0;
        r_d.lamp4 = 1'b0;
        if (mode == `MODE_SINGLE) begin
            r_d.pin_clk = single_on;
        end else if (mode == `MODE_FOUR) begin
            r_d.pin_clk = (four_lit >= 3'h1);
            r_d.pin_dat = (four_lit >= 3'h2);
            r_d.lamp3 = (four_lit >= 3'h3);
            r_d.lamp4 = (four_lit >= 3'h4);
        end else if (ext_mode) begin
            r_d.pin_clk = sh_bus.sclk;
            r_d.pin_dat = sh_bus.sdata;
        end
    end

    // All controller state is registered here.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= '{cfg: `RST_DISPLAY_CONFIG, ctrl: `RST_CONTROL, hold: `RST_HOLD, st: ST_IDLE, default: '0};
        end else begin
            r_q <= r_d;
        end
    end

    assign shift_clock_out = r_q.pin_clk;
    assign shift_data_out = r_q.pin_dat;
    assign lamp3_out = r_q.lamp3;
    assign lamp4_out = r_q.lamp4;

    property p_mode_none_dark;
        @(posedge pclk) disable iff (!presetn)
        (mode == `MODE_NONE) |=> !shift_clock_out && !shift_data_out && !lamp3_out && !lamp4_out;
    endproperty
    a_mode_none_dark: assert property (p_mode_none_dark)
        else $error("No-display mode drove a lamp.");

    property p_aon_lights;
        @(posedge pclk) disable iff (!presetn)
        (aon_eff && r_q.st != ST_SHOW) |=> (r_q.st == ST_SHOW);
    endproperty
    a_aon_lights: assert property (p_aon_lights)
        else $error("Always-on did not light the display.");

    property p_no_show_without_hold;
        @(posedge pclk) disable iff (!presetn)
        (r_q.st == ST_IDLE && !aon_eff) |=> (r_q.st != ST_SHOW);
    endproperty
    a_no_show_without_hold: assert property (p_no_show_without_hold)
        else $error("Display lit without a button hold.");

    property p_hold_expires;
        @(posedge pclk) disable iff (!presetn)
        (active && !aon_eff && sec_tick && (r_q.secs + 8'h01 >= hold_eff)) |=> (r_q.st == ST_RELEASE);
    endproperty
    a_hold_expires: assert property (p_hold_expires)
        else $error("Display outlived its hold time.");

    property p_single_clamp;
        @(posedge pclk) disable iff (!presetn)
        (mode == `MODE_SINGLE && !force_on && r_q.slot >= `SINGLE_CLAMP_PCT) |=> !shift_clock_out;
    endproperty
    a_single_clamp: assert property (p_single_clamp)
        else $error("Single LED lit beyond the 90 percent slot.");

    property p_single_duty;
        @(posedge pclk) disable iff (!presetn)
        (mode == `MODE_SINGLE && active && !force_off && r_q.slot < single_pct) |=> shift_clock_out;
    endproperty
    a_single_duty: assert property (p_single_duty)
        else $error("Single LED dark inside its on time.");

    property p_four_third_quarter;
        @(posedge pclk) disable iff (!presetn)
        (mode == `MODE_FOUR && active && !force_on && !force_off && value > 7'h32 && value <= 7'h4B)
            |=> lamp3_out && !lamp4_out && shift_data_out;
    endproperty
    a_four_third_quarter: assert property (p_four_third_quarter)
        else $error("Third-quarter value did not light exactly three lamps.");

    property p_force_off;
        @(posedge pclk) disable iff (!presetn)
        (force_off && mode == `MODE_FOUR) |=> !shift_clock_out && !lamp3_out && !lamp4_out;
    endproperty
    a_force_off: assert property (p_force_off)
        else $error("Forced-off display still lit.");

    // The shift length follows the count code, and no bit beyond the last LED is ever lit.
    property p_ext_count;
        @(posedge pclk) disable iff (!presetn)
        (sh_bus.start && sh_bus.count != 5'h00)
            |-> (sh_bus.count == 5'(r_q.cfg[`CFG_COUNT_LSB +: 4]) + 5'h01) &&
                ((sh_bus.pattern >> sh_bus.count) == 16'h0000);
    endproperty
    a_ext_count: assert property (p_ext_count)
        else $error("External shift length differs from the configured LED count.");

    // The reserved count code must leave the shifter idle.
    property p_reserved_count_quiet;
        @(posedge pclk) disable iff (!presetn)
        (ext_mode && led_count == 5'h00 && !sh_bus.busy) |=> !sh_bus.busy;
    endproperty
    a_reserved_count_quiet: assert property (p_reserved_count_quiet)
        else $error("Reserved LED count code started a shift.");

    // A seen button level arms the display from idle.
    property p_sense_arms;
        @(posedge pclk) disable iff (!presetn)
        (r_q.st == ST_IDLE && !aon_eff && r_q.sense_sync) |=> (r_q.st == ST_ARM);
    endproperty
    a_sense_arms: assert property (p_sense_arms)
        else $error("Button level did not arm the display.");

    // A button still held after time-out keeps the display dark.
    property p_release_waits;
        @(posedge pclk) disable iff (!presetn)
        (r_q.st == ST_RELEASE && !aon_eff && r_q.sense_sync) |=> (r_q.st == ST_RELEASE);
    endproperty
    a_release_waits: assert property (p_release_waits)
        else $error("Held button relit the display after time-out.");

    c_button_show: cover property (@(posedge pclk) disable iff (!presetn) r_q.st == ST_ARM ##1 r_q.st == ST_SHOW);
    c_single_lit: cover property (@(posedge pclk) disable iff (!presetn) mode == `MODE_SINGLE && active && single_on);
    c_release_held: cover property (@(posedge pclk) disable iff (!presetn) r_q.st == ST_RELEASE && r_q.sense_sync);
    c_ext_send: cover property (@(posedge pclk) disable iff (!presetn) sh_bus.start && led_count > 5'h08);
    c_aon_refresh: cover property (@(posedge pclk) disable iff (!presetn) r_q.refresh && aon_eff);

endmodule // charge_level_led_display

/* tb/led_far_side.sv */
// Far-side model: display button, LED lamps and two chained 8-bit serial shift registers.
`timescale 1ns/100ps
module led_far_side (
    input wire logic press,
    input wire logic arm,
    input wire logic sclk,
    input wire logic sdata,
    output logic sense,
    output logic [15:0] chain,
    output logic setup_bad
);
    time data_t;
    time clk_t;
    // A held button ties the regulator output to the sense pin; released, the pin is pulled low.
    assign sense = press;
    initial begin
        chain = 16'h0000;
        setup_bad = 1'b0;
        data_t = 0;
        clk_t = 0;
    end
    // Data moving just after a shift edge breaks hold; only judged while armed, as lamps share the pins.
    always @(sdata) begin
        if (arm && clk_t > 0 && $time - clk_t < 20) setup_bad = 1'b1;
        data_t = $time;
    end
    // Each rising shift clock moves every bit on by one, so extra or missing clocks show up in chain.
    always @(posedge sclk) begin
        if (arm && $time - data_t < 20) setup_bad = 1'b1;
        clk_t = $time;
        chain = {chain[14:0], sdata};
    end
endmodule // led_far_side

/* tb/tb.sv */
// Self-checking bench for the charge level LED display.
`timescale 1ns/100ps
`include "charge_led_cfg.svh"
module tb;
    localparam int P = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sense, sclk, sdata, lamp3, lamp4, press, arm, setup_bad;
    logic [15:0] chain;
    logic [3:0] lamps;
    int failures, check_count;
    assign lamps = {lamp4, lamp3, sdata, sclk};
    // A short percent step keeps one display second at 512 cycles.
    charge_level_led_display #(.PCT_CYCLES(P)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .display_enable_sense(sense), .shift_clock_out(sclk),
        .shift_data_out(sdata), .lamp3_out(lamp3), .lamp4_out(lamp4));
    led_far_side far (.press(press), .arm(arm), .sclk(sclk), .sdata(sdata), .sense(sense),
        .chain(chain), .setup_bad(setup_bad));
    // Free-running 100 MHz clock.
    always #5 pclk = ~pclk;
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) failures++;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check("read data", exp, r);
        check("slave error", {31'h0, xe}, {31'h0, e});
    endtask
    task automatic wait_sclk(input int lim);
        int n;
        n = 0;
        while (sclk !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic t_regs();
        rd_chk(`OFF_DISPLAY_CONFIG, {24'h0, `RST_DISPLAY_CONFIG}, 1'b0);
        rd_chk(`OFF_HOLD, {24'h0, `RST_HOLD}, 1'b0);
        rd_chk(8'h40, 32'h0, 1'b1);
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_01F0);
        rd_chk(`OFF_DISPLAY_CONFIG, 32'h0000_00F0, 1'b0);
        repeat (20) @(posedge pclk);
        check("mode none", 32'h0, {28'h0, lamps});
        $display("regs done");
    endtask
    task automatic t_button();
        wr(`OFF_HOLD, 32'h1);
        wr(`OFF_CHARGE, 32'h64);
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_0002);
        press <= 1'b1;
        repeat (450) @(posedge pclk);
        check("early", 32'h0, {28'h0, lamps});
        wait_sclk(700);
        check("shown", 32'hF, {28'h0, lamps});
        repeat (400) @(posedge pclk);
        check("held", 32'hF, {28'h0, lamps});
        repeat (200) @(posedge pclk);
        check("expired", 32'h0, {28'h0, lamps});
        press <= 1'b0;
        repeat (20) @(posedge pclk);
        $display("button done");
    endtask
    task automatic t_single();
        int n;
        n = 0;
        wr(`OFF_HOLD, 32'h4);
        wr(`OFF_CHARGE, 32'h5F);
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_0009);
        repeat (300) @(posedge pclk);
        check("single idle", 32'h0, {31'h0, sclk});
        press <= 1'b1;
        wait_sclk(1200);
        repeat (512) begin
            n += (sclk === 1'b1);
            @(posedge pclk);
        end
        press <= 1'b0;
        check("on time", 90 * P, n);
        $display("single done");
    endtask
    task automatic t_ext();
        arm <= 1'b1;
        wr(`OFF_CHARGE, 32'h32);
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_003B);
        repeat (400) @(posedge pclk);
        check("four ext", 32'h3, {28'h0, chain[3:0]});
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_000C);
        wr(`OFF_HEALTH, 32'h64);
        wr(`OFF_CONTROL, 32'h1);
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_008C);
        repeat (700) @(posedge pclk);
        check("nine ext", 32'h7FF, {19'h0, chain[12:0]});
        check("setup", 32'h0, {31'h0, setup_bad});
        arm <= 1'b0;
        wr(`OFF_CONTROL, 32'h0);
        $display("external done");
    endtask
    task automatic t_four();
        int tab[8] = '{0, 1, 25, 26, 67, 75, 76, 100};
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_000A);
        foreach (tab[i]) begin
            wr(`OFF_CHARGE, tab[i]);
            repeat (5) @(posedge pclk);
            check("four", (32'h1 << ((tab[i] + 24) / 25)) - 1, {28'h0, lamps});
        end
        $display("four done");
    endtask
    task automatic t_force();
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_0002);
        wr(`OFF_CHARGE, 32'h0);
        wr(`OFF_CONTROL, 32'h2);
        repeat (5) @(posedge pclk);
        check("forced on", 32'hF, {28'h0, lamps});
        wr(`OFF_CONTROL, 32'h6);
        wr(`OFF_DISPLAY_CONFIG, 32'h0000_000A);
        wr(`OFF_CHARGE, 32'h64);
        repeat (5) @(posedge pclk);
        check("forced off", 32'h0, {28'h0, lamps});
        $display("force done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, press, arm} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        check_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_button();
        t_single();
        t_ext();
        t_four();
        t_force();
        report_and_stop();
    end
    // The scenarios need about 4300 cycles; a hang is cut off well beyond that.
    initial begin
        #300000;
        failures++;
        report_and_stop();
    end
endmodule // tb
